/* File: logic/ext_irq_pkg.sv */
// Purpose: Constants for the external pin interrupt unit
// Assumes: 125 MHz system clock, plain register port
// Notes:   Register offsets are local choices
//
// How it works
// - Pin-one sense field: 00 low, 01 change, 10 fall, 11 rise
// - Pin-zero sense field uses the same four encodings
// - Request taken only when global enable and pin enable are set
// - Pins zero and one sampled first; pulses over one clock are seen
// - Pin two edge only: sense bit 0 falling, 1 rising
// - Pin two edges caught without clock; 50 ns pulses always seen
// - Enable register bits: 7 pin one, 6 pin zero, 5 pin two
// - Pin activity raises requests even when the pin drives out
// - Each pin request goes to its own vector line
// - Flags at bits 7, 6, 5 set on trigger; bits 4..0 read zero
// - Flag cleared on vector entry or by writing one
// - Flag held at zero while its pin uses low-level sensing
// - Pin-two buffer off in sleep while disabled may set its flag
// - Low-level request keeps asserting while pin stays low
// - Pin-two edges work without the I/O clock; low level is sampled on it
package ext_irq_pkg;
  localparam logic [1:0] ADDR_CORE_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_EXT_CONTROL  = 2'h1;
  localparam logic [1:0] ADDR_ENABLE       = 2'h2;
  localparam logic [1:0] ADDR_FLAGS        = 2'h3;
  localparam int         BIT_PIN_ONE       = 7;
  localparam int         BIT_PIN_ZERO      = 6;
  localparam int         BIT_PIN_TWO       = 5;
  localparam int         SENSE_ONE_LSB     = 2;
  localparam int         SENSE_ZERO_LSB    = 0;
  localparam int         SENSE_TWO_BIT     = 0;
  localparam logic [7:0] RESET_BYTE        = 8'h00;
  localparam logic [7:0] FLAG_MASK         = 8'hE0;
  localparam logic [1:0] SENSE_LOW         = 2'h0;
  localparam logic [1:0] SENSE_CHANGE      = 2'h1;
  localparam logic [1:0] SENSE_FALL        = 2'h2;
  localparam logic [1:0] SENSE_RISE        = 2'h3;
  localparam int         MIN_PULSE_NS      = 50;
  localparam int         CLK_MHZ           = 125;
  localparam int         MIN_PULSE_CYCLES  = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
endpackage : ext_irq_pkg

/* File: logic/async_edge_catch.sv */
// Purpose: Clockless edge catcher for pin two
// Assumes: Pin toggles slower than the three-flop synchroniser
// Notes:   Toggle flop on the pin, result synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module async_edge_catch (
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  input  wire logic pin_in,
  input  wire logic rise_sel_in,
  output logic      event_out
);
  logic pin_edge;
  logic toggle;
  logic sync_a;
  logic sync_b;
  logic sync_c;

  // Select polarity so one flop edge serves both senses
  assign pin_edge = pin_in ^ ~rise_sel_in;

  // ****************
  // Clockless capture
  // ****************
  // Pin edge clocks
  always_ff @(posedge pin_edge or negedge resetn_in) begin
    if (!resetn_in) begin
      toggle <= 1'b0;
    end else begin
      toggle <= ~toggle;
    end
  end

  // Toggle crosses into clk domain; first flop read only by second
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_a    <= 1'b0;
      sync_b    <= 1'b0;
      sync_c    <= 1'b0;
      event_out <= 1'b0;
    end else begin
      sync_a    <= toggle;
      sync_b    <= sync_a;
      sync_c    <= sync_b;
      event_out <= sync_b ^ sync_c;
    end
  end
endmodule : async_edge_catch
`default_nettype wire

/* File: logic/ext_pin_irq.sv */
// Purpose: External pin interrupt unit with three request pins
// Assumes: One clock; pins asynchronous to it
// Notes:   Vector-entry clear comes from the core as a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module ext_pin_irq (
  input  wire logic       clk_sys_in,
  input  wire logic       resetn_in,
  input  wire logic [1:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       ext_req_pin_zero_in,
  input  wire logic       ext_req_pin_one_in,
  input  wire logic       ext_req_pin_two_in,
  input  wire logic       global_enable_in,
  input  wire logic [2:0] vector_ack_in,
  input  wire logic       sleep_buffer_off_in,
  output logic      [2:0] vector_req_out,
  output logic            irq_out
);
  logic [7:0] core_control;
  logic [7:0] extended_control;
  logic [7:0] pin_interrupt_enable;
  logic [7:0] pin_interrupt_flags;
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] prev;
  logic [1:0] trig;
  logic [1:0] low_level;
  logic       pin_two_event;
  logic       pin_two_eff;
  logic [1:0] sense_zero;
  logic [1:0] sense_one;
  logic [2:0] enables;
  logic [2:0] flags;
  logic [2:0] pending;
  logic [7:0] next_flags;

  assign sense_zero = core_control[ext_irq_pkg::SENSE_ZERO_LSB +: 2];
  assign sense_one  = core_control[ext_irq_pkg::SENSE_ONE_LSB +: 2];

  // ****************
  // Pin sampling
  // ****************
  // Two-stage synchroniser
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_a <= 2'h3;
      sync_b <= 2'h3;
      prev   <= 2'h3;
    end else begin
      sync_a <= {ext_req_pin_one_in, ext_req_pin_zero_in};
      sync_b <= sync_a;
      prev   <= sync_b;
    end
  end

  function automatic logic detect(input logic [1:0] sense, input logic cur, input logic old);
    case (sense)
      ext_irq_pkg::SENSE_CHANGE: detect = cur ^ old;
      ext_irq_pkg::SENSE_FALL:   detect = old & ~cur;
      ext_irq_pkg::SENSE_RISE:   detect = ~old & cur;
      default:                   detect = 1'b0;
    endcase
  endfunction : detect

  assign trig[0] = detect(sense_zero, sync_b[0], prev[0]);
  assign trig[1] = detect(sense_one, sync_b[1], prev[1]);
  assign low_level[0] = (sense_zero == ext_irq_pkg::SENSE_LOW) & ~sync_b[0];
  assign low_level[1] = (sense_one == ext_irq_pkg::SENSE_LOW) & ~sync_b[1];

  assign pin_two_eff = ext_req_pin_two_in & ~sleep_buffer_off_in;

  async_edge_catch u_pin_two (
    .clk_sys_in  (clk_sys_in),
    .resetn_in   (resetn_in),
    .pin_in      (pin_two_eff),
    .rise_sel_in (extended_control[ext_irq_pkg::SENSE_TWO_BIT]),
    .event_out   (pin_two_event)
  );

  // ****************
  // Registers
  // ****************
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      core_control         <= ext_irq_pkg::RESET_BYTE;
      extended_control     <= ext_irq_pkg::RESET_BYTE;
      pin_interrupt_enable <= ext_irq_pkg::RESET_BYTE;
    end else if (wr_in) begin
      case (addr_in)
        ext_irq_pkg::ADDR_CORE_CONTROL: core_control <= wdata_in;
        // Sense change may raise a flag
        ext_irq_pkg::ADDR_EXT_CONTROL:  extended_control <= wdata_in;
        ext_irq_pkg::ADDR_ENABLE: begin
          pin_interrupt_enable <= wdata_in & ext_irq_pkg::FLAG_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************
  // Flags
  // ****************
  always_comb begin
    next_flags = pin_interrupt_flags;
    if (wr_in && addr_in == ext_irq_pkg::ADDR_FLAGS) begin
      next_flags = next_flags & ~wdata_in;
    end
    if (vector_ack_in[0]) next_flags[ext_irq_pkg::BIT_PIN_ZERO] = 1'b0;
    if (vector_ack_in[1]) next_flags[ext_irq_pkg::BIT_PIN_ONE] = 1'b0;
    if (vector_ack_in[2]) next_flags[ext_irq_pkg::BIT_PIN_TWO] = 1'b0;
    if (trig[0]) next_flags[ext_irq_pkg::BIT_PIN_ZERO] = 1'b1;
    if (trig[1]) next_flags[ext_irq_pkg::BIT_PIN_ONE] = 1'b1;
    if (pin_two_event) next_flags[ext_irq_pkg::BIT_PIN_TWO] = 1'b1;
    if (sense_zero == ext_irq_pkg::SENSE_LOW) next_flags[ext_irq_pkg::BIT_PIN_ZERO] = 1'b0;
    if (sense_one == ext_irq_pkg::SENSE_LOW) next_flags[ext_irq_pkg::BIT_PIN_ONE] = 1'b0;
    next_flags = next_flags & ext_irq_pkg::FLAG_MASK;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_interrupt_flags <= ext_irq_pkg::RESET_BYTE;
    end else begin
      pin_interrupt_flags <= next_flags;
    end
  end

  // ****************
  // Dispatch
  // ****************
  assign flags   = {pin_interrupt_flags[ext_irq_pkg::BIT_PIN_TWO],
                    pin_interrupt_flags[ext_irq_pkg::BIT_PIN_ONE],
                    pin_interrupt_flags[ext_irq_pkg::BIT_PIN_ZERO]};
  assign enables = {pin_interrupt_enable[ext_irq_pkg::BIT_PIN_TWO],
                    pin_interrupt_enable[ext_irq_pkg::BIT_PIN_ONE],
                    pin_interrupt_enable[ext_irq_pkg::BIT_PIN_ZERO]};
  assign pending = (flags | {1'b0, low_level}) & enables;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vector_req_out <= 3'h0;
      irq_out        <= 1'b0;
    end else begin
      vector_req_out <= pending & {3{global_enable_in}};
      irq_out        <= global_enable_in & (|pending);
    end
  end

  // Read data one cycle after strobe, zero otherwise
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= ext_irq_pkg::RESET_BYTE;
    end else if (rd_in) begin
      case (addr_in)
        ext_irq_pkg::ADDR_CORE_CONTROL: rdata_out <= core_control;
        ext_irq_pkg::ADDR_EXT_CONTROL:  rdata_out <= extended_control;
        ext_irq_pkg::ADDR_ENABLE:       rdata_out <= pin_interrupt_enable;
        default:                        rdata_out <= pin_interrupt_flags;
      endcase
    end else begin
      rdata_out <= ext_irq_pkg::RESET_BYTE;
    end
  end
endmodule : ext_pin_irq
`default_nettype wire

/* File: tb/ext_pin_irq_props.sv */
// Purpose: Port checks for ext_pin_irq
// Assumes: Registered outputs, one clock
// Notes:   Bound to the design at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module ext_pin_irq_props (
  input  wire logic       clk_sys_in,
  input  wire logic       resetn_in,
  input  wire logic [1:0] addr_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic [7:0] rdata_out,
  input  wire logic       ext_req_pin_zero_in,
  input  wire logic       global_enable_in,
  input  wire logic [2:0] vector_ack_in,
  input  wire logic [2:0] vector_req_out,
  input  wire logic       irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  a_rdata_quiet: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data without a read");
  a_flag_low_bits: assert property (
    $past(rd_in) && $past(addr_in) == 2'h3 |-> rdata_out[4:0] == 5'h00)
    else $error("flag bits 4..0 set");
  a_enable_bits: assert property (
    $past(rd_in) && $past(addr_in) == 2'h2 |-> rdata_out[4:0] == 5'h00)
    else $error("enable bits 4..0 set");
  a_global_gate: assert property (!$past(global_enable_in) |-> vector_req_out == 3'h0)
    else $error("request without global enable");
  a_global_drop: assert property (
    $fell(global_enable_in) ##1 !global_enable_in |=> !irq_out) else $error("irq after disable");
  a_irq_follow: assert property (|vector_req_out |-> ##[0:1] irq_out)
    else $error("request without irq");
  a_irq_cause: assert property (
    irq_out |-> (|vector_req_out) || (|$past(vector_req_out))) else $error("irq without request");
  a_low_hold: assert property (
    vector_req_out[0] && !ext_req_pin_zero_in && !$past(ext_req_pin_zero_in)
    && !$past(ext_req_pin_zero_in, 2) && !$past(wr_in) && !$past(vector_ack_in[0])
    && $past(global_enable_in)
    && !wr_in && vector_ack_in == 3'h0 && global_enable_in |=> vector_req_out[0])
    else $error("pin zero request dropped while low");
  cover property ($rose(vector_req_out[0]));
  cover property ($rose(vector_req_out[1]));
  cover property ($rose(vector_req_out[2]));
endmodule : ext_pin_irq_props
bind ext_pin_irq ext_pin_irq_props u_props (.clk_sys_in, .resetn_in, .addr_in, .wr_in,
  .rd_in, .rdata_out, .ext_req_pin_zero_in, .global_enable_in, .vector_ack_in,
  .vector_req_out, .irq_out);
`default_nettype wire

/* File: tb/pin_source.sv */
// Purpose: Off-chip sources driving the three request pins
// Assumes: Pins always driven, idle high
// Notes:   Timing is free of the system clock
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  output logic pin_zero_out,
  output logic pin_one_out,
  output logic pin_two_out
);
  initial begin
    pin_zero_out = 1'b1;
    pin_one_out = 1'b1;
    pin_two_out = 1'b1;
  end
  task automatic set_pins(input logic lvl, input int hold_ns);
    pin_zero_out = lvl;
    pin_one_out = lvl;
    pin_two_out = lvl;
    #(hold_ns);
  endtask : set_pins
  task automatic pulse_two(input logic lvl, input int width_ns);
    pin_two_out = lvl;
    #(width_ns);
    pin_two_out = ~lvl;
  endtask : pulse_two
  // pulse on pin zero just over one clock
  task automatic pulse_zero(input int width_ns);
    pin_zero_out = 1'b0;
    #(width_ns);
    pin_zero_out = 1'b1;
  endtask : pulse_zero
endmodule : pin_source
`default_nettype wire

/* File: tb/ext_pin_irq_tb_top.sv */
// Purpose: Bench for the external pin interrupt unit
// Assumes: Plain register port, pins from u_pin_source
// Notes:   Sleep may set the pin-two flag, so it is cleared
`timescale 1ns/1ps
`default_nettype none
module ext_pin_irq_tb_top;
  logic       clk_sys_in = 1'b0;
  logic       resetn_in = 1'b1;
  logic [1:0] addr_in = 2'h0;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0;
  logic       rd_in = 1'b0;
  logic       global_enable_in = 1'b0;
  logic [2:0] vector_ack_in = 3'h0;
  logic       sleep_buffer_off_in = 1'b0;
  wire logic [7:0] rdata_out;
  wire logic [2:0] vector_req_out;
  wire logic  irq_out, p0, p1, p2;
  logic [1:0] m;
  logic       lvl, e, e2;
  int         num_errors = 0;
  int         checks_done = 0;
  logic [2:0] steps [6] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h2, 3'h3};
  localparam logic [1:0] RISE = ext_irq_pkg::SENSE_RISE;
  always #4 clk_sys_in = ~clk_sys_in;
  pin_source u_pin_source (.pin_zero_out(p0), .pin_one_out(p1), .pin_two_out(p2));
  ext_pin_irq u_ext_pin_irq (.clk_sys_in, .resetn_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .ext_req_pin_zero_in(p0), .ext_req_pin_one_in(p1),
    .ext_req_pin_two_in(p2), .global_enable_in, .vector_ack_in, .sleep_buffer_off_in,
    .vector_req_out, .irq_out);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    @(posedge clk_sys_in);
    chk(rdata_out, exp);
  endtask : rd
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // ****************
  // Tests
  // ****************
  initial begin
    // Falling edge needed, the clockless catcher has no other reset
    resetn_in <= 1'b0;
    repeat (16) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    for (int a = 0; a < 4; a++) rd(2'(a), 8'h00);
    wr(2'h2, 8'hFF);
    rd(2'h2, 8'hE0);
    global_enable_in <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      {m, lvl} = steps[i];
      e = (m == ext_irq_pkg::SENSE_CHANGE) || ((m == RISE) == lvl);
      e2 = (m == RISE) == lvl;
      wr(2'h2, 8'h00);
      wr(2'h0, {4'h0, m, m});
      wr(2'h1, {7'h00, m == RISE});
      // Sense change event must land before the clear
      repeat (8) @(posedge clk_sys_in);
      wr(2'h3, 8'hE0);
      wr(2'h2, 8'hE0);
      u_pin_source.set_pins(lvl, 40);
      repeat (8) @(posedge clk_sys_in);
      rd(2'h3, {e, e, e2, 5'h00});
      chk({4'h0, irq_out, vector_req_out}, {4'h0, e | e2, e2, e, e});
    end
    global_enable_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    chk({5'h00, vector_req_out}, 8'h00);
    global_enable_in <= 1'b1;
    wr(2'h3, 8'h00);
    rd(2'h3, 8'hC0);
    wr(2'h3, 8'hE0);
    u_pin_source.pulse_zero(12);
    repeat (8) @(posedge clk_sys_in);
    rd(2'h3, 8'h40);
    wr(2'h0, 8'h00);
    rd(2'h3, 8'h00);
    u_pin_source.set_pins(1'b0, 40);
    repeat (8) @(posedge clk_sys_in);
    chk({5'h00, vector_req_out}, 8'h07);
    u_pin_source.set_pins(1'b1, 40);
    repeat (8) @(posedge clk_sys_in);
    chk({5'h00, vector_req_out}, 8'h04);
    @(posedge clk_sys_in) vector_ack_in <= 3'h4;
    @(posedge clk_sys_in) vector_ack_in <= 3'h0;
    rd(2'h3, 8'h00);
    wr(2'h1, 8'h01);
    repeat (8) @(posedge clk_sys_in);
    wr(2'h3, 8'hE0);
    u_pin_source.pulse_two(1'b0, 60);
    repeat (8) @(posedge clk_sys_in);
    rd(2'h3, 8'h20);
    wr(2'h2, 8'hC0);
    wr(2'h3, 8'hE0);
    sleep_buffer_off_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    sleep_buffer_off_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    rd(2'h3, 8'h20);
    chk({5'h00, vector_req_out}, 8'h00);
    wr(2'h3, 8'hE0);
    rd(2'h3, 8'h00);
    rd(2'h2, 8'hC0);
    tally_and_finish();
  end
  // Generous: the tests need well under ten microseconds
  initial begin
    #50000;
    num_errors++;
    tally_and_finish();
  end
endmodule : ext_pin_irq_tb_top
`default_nettype wire
